// ---- inc/rail_fault_regs.vh ----
`ifndef RAIL_FAULT_REGS_VH
`define RAIL_FAULT_REGS_VH
// rails and history
`define NRAIL 10
`define LAST_RAIL 4'h9
`define HIST_LEN 5'h10
`define RETRY_MAX 4'he
// timing
`define CLK_NS 25
`define SAMPLE_US 400
`define TEMP_MS 100
`define RSTEP_MS 5
// per-rail field index, address = {page, rail, field}
`define F_OVF 4'h0
`define F_OVW 4'h1
`define F_UVW 4'h2
`define F_UVF 4'h3
`define F_PGON 4'h4
`define F_NOM 4'h5
`define F_CFG 4'h6
`define F_GLITCH 4'h7
`define F_TONMAX 4'h8
`define F_TOFFMAX 4'h9
`define F_RDLY 4'ha
`define F_TEMP 4'hb
`define F_OTW 4'hc
`define F_OTF 4'hd
`define F_STAT 4'he
`define F_SLAVE 4'hf
// page-one fields, read-only except the write-one-clear log
`define P1_PEAK 4'h0
`define P1_LOG 4'h1
`define P1_VOLT 4'h2
`define P1_STATE 4'h3
// global register
`define A_RAILON 8'hf0
// cfg bits
`define C_RESP_LO 0
`define C_RMODE_LO 2
`define C_RCNT_LO 4
`define C_GLEN 8
`define C_TMON 9
`define C_WPIN 10
// fault responses
`define RESP_CONT 2'h0
`define RESP_SHUT 2'h1
`define RESP_SEQ 2'h2
`define RESP_RESEQ 2'h3
// restart modes
`define RM_NONE 2'h0
`define RM_N 2'h1
// status bits
`define S_OVF 0
`define S_OVW 1
`define S_UVW 2
`define S_UVF 3
`define S_TON 4
`define S_TOFF 5
`define S_OTW 6
`define S_OTF 7
// reset values
`define CFG_RST 12'h000
`define RAILON_RST 10'h000
// rail states
`define ST_OFF 3'h0
`define ST_RAMP 3'h1
`define ST_ON 3'h2
`define ST_DOWN 3'h3
`define ST_RDLY 3'h4
`define ST_LOCK 3'h5
`endif

// ---- verilog/temp_hist_mem.v ----
`timescale 1ns/1ps
// sample history, registered read
module temp_hist_mem #(
  parameter DEPTH = 160
) (
  input wire clk,
  input wire we,
  input wire [7:0] waddr,
  input wire [11:0] wdata,
  input wire [7:0] raddr,
  output reg [11:0] rdata_r
);
  reg [11:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule

// ---- verilog/rail_fault_monitor.v ----
`timescale 1ns/1ps
`include "rail_fault_regs.vh"
module rail_fault_monitor #(
  parameter SAMPLE_CYC = `SAMPLE_US * 1000 / `CLK_NS,
  parameter TEMP_CYC = `TEMP_MS * 1000000 / `CLK_NS,
  parameter STEP_CYC = `RSTEP_MS * 1000000 / `CLK_NS
) (
  input wire clk,
  input wire rst_n,
  input wire [8:0] addr,
  input wire [11:0] wdata,
  input wire wr,
  input wire rd,
  output reg [11:0] rdata_r,
  input wire adc_valid,
  input wire [3:0] adc_rail,
  input wire [1:0] adc_kind,
  input wire [11:0] adc_data,
  input wire rail_control_pin,
  output reg [9:0] rail_en_r,
  output reg alert_out_n,
  output reg warn_pin_r
);
  localparam [21:0] S_LAST = SAMPLE_CYC - 1;
  localparam [21:0] T_LAST = TEMP_CYC - 1;
  localparam [21:0] P_LAST = STEP_CYC - 1;

  integer i;
  reg [11:0] cfg_r [0:159];
  reg [2:0] st_r [0:9];
  reg [11:0] tmr_r [0:9];
  reg [7:0] gl_r [0:9];
  reg [3:0] rcnt_r [0:9];
  reg [7:0] stat_r [0:9];
  reg [7:0] log_r [0:9];
  reg [11:0] vraw_r [0:9];
  reg [11:0] traw_r [0:9];
  reg [11:0] host_r [0:9];
  reg [11:0] peak_r [0:9];
  reg [11:0] avg_r [0:9];
  reg [15:0] sum_r [0:9];
  reg [4:0] cnt_r [0:9];
  reg [3:0] widx_r [0:9];
  reg [9:0] hostv_r;
  reg [9:0] rseq_r;
  reg [9:0] rail_on_r;
  reg [11:0] die_r;
  reg ctrl_s1_r;
  reg ctrl_s2_r;
  reg [21:0] scnt_r;
  reg [21:0] tcnt_r;
  reg [21:0] pcnt_r;
  reg scan_r;
  reg [3:0] ptr_r;
  reg t1_r;
  reg t2_r;
  reg [3:0] tptr_r;
  reg [11:0] tsamp_r;
  reg [11:0] rd_nxt;

  wire [3:0] arail = addr[7:4];
  wire [3:0] afld = addr[3:0];
  wire pg0 = ~addr[8];
  wire rail_ok = arail < 4'ha;
  wire stick = scnt_r == S_LAST;
  wire ttick = tcnt_r == T_LAST;
  wire ptick = pcnt_r == P_LAST;
  wire [9:0] on_v = rail_on_r & {10{ctrl_s2_r}};
  wire [11:0] old_w;
  wire [11:0] tnow [0:9];
  wire [9:0] hit_v;
  wire [9:0] flt_v;
  wire [9:0] go_v;
  wire [9:0] pgok_v;
  wire [9:0] low_v;
  wire [9:0] tonx_v;
  wire [9:0] toffx_v;
  wire [9:0] rdok_v;
  wire [9:0] warn_v;
  wire [7:0] set_v [0:9];
  wire [7:0] logset_v [0:9];

  // temperature filter arithmetic for the rail in stage two
  wire full_w = cnt_r[tptr_r] == `HIST_LEN;
  wire [15:0] nsum_w = sum_r[tptr_r] + {4'h0, tsamp_r} - (full_w ? {4'h0, old_w} : 16'h0000);
  wire [4:0] ncnt_w = full_w ? `HIST_LEN : cnt_r[tptr_r] + 5'h01;
  wire [15:0] navg_w = nsum_w / {11'h000, ncnt_w};
  wire [11:0] tmon_src = cfg_r[{tptr_r, `F_CFG}][`C_TMON] ? traw_r[tptr_r] : die_r;

  // slaves of the rail being checked
  wire [11:0] pcfg = cfg_r[{ptr_r, `F_CFG}];
  wire [1:0] presp = pcfg[`C_RESP_LO +: 2];
  wire psl = |go_v & presp[1];
  wire [9:0] sgo_v = {10{psl}} & cfg_r[{ptr_r, `F_SLAVE}][9:0] & ~hit_v;

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : rail
      localparam [3:0] IDX = g;
      wire [11:0] v = vraw_r[g];
      wire [11:0] c = cfg_r[g * 16 + 6];
      wire ovf = v > cfg_r[g * 16 + 0];
      wire ovw = v > cfg_r[g * 16 + 1];
      wire uv_on = st_r[g] == `ST_ON;
      wire uvw = uv_on & (v < cfg_r[g * 16 + 2]);
      wire uvf = uv_on & (v < cfg_r[g * 16 + 3]);
      wire otw = tnow[g] > cfg_r[g * 16 + 12];
      wire otf = tnow[g] > cfg_r[g * 16 + 13];
      wire ton = hit_v[g] & (st_r[g] == `ST_RAMP) & tonx_v[g] & ~pgok_v[g];
      wire toff = hit_v[g] & (st_r[g] == `ST_DOWN) & toffx_v[g] & ~low_v[g];
      wire glpass = ~c[`C_GLEN] | (gl_r[g] >= cfg_r[g * 16 + 7][7:0]);
      assign hit_v[g] = scan_r & (ptr_r == IDX);
      assign flt_v[g] = ovf | uvf;
      assign pgok_v[g] = v >= cfg_r[g * 16 + 4];
      assign low_v[g] = v < {3'h0, cfg_r[g * 16 + 5][11:3]};
      assign tonx_v[g] = tmr_r[g] >= cfg_r[g * 16 + 8];
      assign toffx_v[g] = tmr_r[g] >= cfg_r[g * 16 + 9];
      assign rdok_v[g] = tmr_r[g] >= {4'h0, cfg_r[g * 16 + 10][7:0]};
      assign go_v[g] = hit_v[g] & ((flt_v[g] & glpass) | ton) & (c[1:0] != `RESP_CONT);
      assign set_v[g] = {otf, otw, toff, ton, {4{hit_v[g]}} & {uvf, uvw, ovw, ovf}};
      assign logset_v[g] = {5'h00, ton, {2{hit_v[g]}} & {uvf, ovf}};
      assign warn_v[g] = c[`C_WPIN] & |(stat_r[g] & 8'h66);
      // host value wins, then average, then raw before any history
      assign tnow[g] = hostv_r[g] ? host_r[g] :
        ((cnt_r[g] == 5'h00) ? (c[`C_TMON] ? traw_r[g] : die_r) : avg_r[g]);
    end
  endgenerate

  temp_hist_mem #(
    .DEPTH(160)
  ) u_hist (
    .clk(clk),
    .we(t2_r),
    .waddr({tptr_r, widx_r[tptr_r]}),
    .wdata(tsamp_r),
    .raddr({tptr_r, widx_r[tptr_r]}),
    .rdata_r(old_w)
  );

  // register read mux
  always @* begin
    rd_nxt = 12'h000;
    if (pg0 && rail_ok) begin
      case (afld)
        `F_TEMP: rd_nxt = tnow[arail];
        `F_STAT: rd_nxt = {4'h0, stat_r[arail]};
        default: rd_nxt = cfg_r[addr[7:0]];
      endcase
    end else if (pg0 && addr[7:0] == `A_RAILON) begin
      rd_nxt = {2'h0, rail_on_r};
    end else if (!pg0 && rail_ok) begin
      case (afld)
        `P1_PEAK: rd_nxt = peak_r[arail];
        `P1_LOG: rd_nxt = {4'h0, log_r[arail]};
        `P1_VOLT: rd_nxt = vraw_r[arail];
        `P1_STATE: rd_nxt = {5'h00, rcnt_r[arail], st_r[arail]};
        default: rd_nxt = 12'h000;
      endcase
    end
  end

  // bus, timers, adc capture and temperature pipeline
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 12'h000;
      rail_on_r <= `RAILON_RST;
      hostv_r <= 10'h000;
      die_r <= 12'h000;
      ctrl_s1_r <= 1'b0;
      ctrl_s2_r <= 1'b0;
      scnt_r <= 22'h000000;
      tcnt_r <= 22'h000000;
      pcnt_r <= 22'h000000;
      scan_r <= 1'b0;
      ptr_r <= 4'h0;
      t1_r <= 1'b0;
      t2_r <= 1'b0;
      tptr_r <= 4'h0;
      tsamp_r <= 12'h000;
      alert_out_n <= 1'b1;
      warn_pin_r <= 1'b0;
      for (i = 0; i < 160; i = i + 1) begin
        cfg_r[i] <= `CFG_RST;
      end
      for (i = 0; i < 10; i = i + 1) begin
        vraw_r[i] <= 12'h000;
        traw_r[i] <= 12'h000;
        host_r[i] <= 12'h000;
        avg_r[i] <= 12'h000;
        sum_r[i] <= 16'h0000;
        cnt_r[i] <= 5'h00;
        widx_r[i] <= 4'h0;
      end
    end else begin
      rdata_r <= rd ? rd_nxt : 12'h000;
      ctrl_s1_r <= rail_control_pin;
      ctrl_s2_r <= ctrl_s1_r;
      if (wr && pg0 && rail_ok) begin
        if (afld == `F_TEMP) begin
          host_r[arail] <= wdata;
          hostv_r[arail] <= 1'b1;
        end else if (afld != `F_STAT) begin
          cfg_r[addr[7:0]] <= wdata;
        end
      end
      if (wr && pg0 && addr[7:0] == `A_RAILON) begin
        rail_on_r <= wdata[9:0];
      end
      if (adc_valid) begin
        case (adc_kind)
          2'h0: vraw_r[adc_rail] <= adc_data;
          2'h1: traw_r[adc_rail] <= adc_data;
          2'h2: die_r <= adc_data;
          default: die_r <= die_r;
        endcase
      end
      scnt_r <= stick ? 22'h000000 : scnt_r + 22'h000001;
      tcnt_r <= ttick ? 22'h000000 : tcnt_r + 22'h000001;
      pcnt_r <= ptick ? 22'h000000 : pcnt_r + 22'h000001;
      if (stick) begin
        scan_r <= 1'b1;
        ptr_r <= 4'h0;
      end else if (scan_r) begin
        scan_r <= ptr_r != `LAST_RAIL;
        ptr_r <= ptr_r + 4'h1;
      end
      t1_r <= ttick;
      t2_r <= t1_r;
      if (t1_r) begin
        tsamp_r <= tmon_src;
      end
      if (t2_r) begin
        sum_r[tptr_r] <= nsum_w;
        cnt_r[tptr_r] <= ncnt_w;
        avg_r[tptr_r] <= navg_w[11:0];
        widx_r[tptr_r] <= widx_r[tptr_r] + 4'h1;
        tptr_r <= (tptr_r == `LAST_RAIL) ? 4'h0 : tptr_r + 4'h1;
      end
      alert_out_n <= ~(|{stat_r[0], stat_r[1], stat_r[2], stat_r[3], stat_r[4],
        stat_r[5], stat_r[6], stat_r[7], stat_r[8], stat_r[9]});
      warn_pin_r <= |warn_v;
    end
  end

  // per-rail status, log and enable state machine
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rseq_r <= 10'h000;
      rail_en_r <= 10'h000;
      for (i = 0; i < 10; i = i + 1) begin
        st_r[i] <= `ST_OFF;
        tmr_r[i] <= 12'h000;
        gl_r[i] <= 8'h00;
        rcnt_r[i] <= 4'h0;
        stat_r[i] <= 8'h00;
        log_r[i] <= 8'h00;
        peak_r[i] <= 12'h000;
      end
    end else begin
      for (i = 0; i < 10; i = i + 1) begin
        // set wins over a write-one clear
        if (wr && pg0 && arail == i && afld == `F_STAT) begin
          stat_r[i] <= (stat_r[i] & ~wdata[7:0]) | set_v[i];
        end else begin
          stat_r[i] <= stat_r[i] | set_v[i];
        end
        if (wr && !pg0 && arail == i && afld == `P1_LOG) begin
          log_r[i] <= (log_r[i] & ~wdata[7:0]) | logset_v[i];
        end else begin
          log_r[i] <= log_r[i] | logset_v[i];
        end
        if (tnow[i] > peak_r[i]) begin
          peak_r[i] <= tnow[i];
        end
        if (hit_v[i]) begin
          if (!flt_v[i]) begin
            gl_r[i] <= 8'h00;
          end else if (gl_r[i] != 8'hff) begin
            gl_r[i] <= gl_r[i] + 8'h01;
          end
        end
        rail_en_r[i] <= (st_r[i] == `ST_RAMP) || (st_r[i] == `ST_ON);
        if (!on_v[i]) begin
          rcnt_r[i] <= 4'h0;
          rseq_r[i] <= 1'b0;
          case (st_r[i])
            `ST_OFF: st_r[i] <= `ST_OFF;
            `ST_DOWN: begin
              if (hit_v[i]) begin
                tmr_r[i] <= tmr_r[i] + 12'h001;
                if (low_v[i] || toffx_v[i]) begin
                  st_r[i] <= `ST_OFF;
                end
              end
            end
            default: begin
              st_r[i] <= `ST_DOWN;
              tmr_r[i] <= 12'h000;
            end
          endcase
        end else begin
          case (st_r[i])
            `ST_OFF: begin
              st_r[i] <= `ST_RAMP;
              tmr_r[i] <= 12'h000;
            end
            `ST_RAMP, `ST_ON: begin
              if (go_v[i]) begin
                st_r[i] <= `ST_DOWN;
                tmr_r[i] <= 12'h000;
                rseq_r[i] <= cfg_r[i * 16 + 6][1:0] == `RESP_RESEQ;
              end else if (hit_v[i] && st_r[i] == `ST_RAMP) begin
                if (pgok_v[i]) begin
                  st_r[i] <= `ST_ON;
                end else begin
                  tmr_r[i] <= tmr_r[i] + 12'h001;
                end
              end
            end
            `ST_DOWN: begin
              if (hit_v[i]) begin
                tmr_r[i] <= tmr_r[i] + 12'h001;
                if (low_v[i] || toffx_v[i]) begin
                  tmr_r[i] <= 12'h000;
                  if (rseq_r[i]) begin
                    st_r[i] <= `ST_RDLY;
                  end else begin
                    case (cfg_r[i * 16 + 6][3:2])
                      `RM_NONE: st_r[i] <= `ST_LOCK;
                      `RM_N: begin
                        if (rcnt_r[i] < cfg_r[i * 16 + 6][7:4] && rcnt_r[i] < `RETRY_MAX) begin
                          st_r[i] <= `ST_RDLY;
                          rcnt_r[i] <= rcnt_r[i] + 4'h1;
                        end else begin
                          st_r[i] <= `ST_LOCK;
                        end
                      end
                      default: st_r[i] <= `ST_RDLY;
                    endcase
                  end
                end
              end
            end
            `ST_RDLY: begin
              if (ptick) begin
                if (rdok_v[i]) begin
                  st_r[i] <= `ST_RAMP;
                  tmr_r[i] <= 12'h000;
                  rseq_r[i] <= 1'b0;
                end else begin
                  tmr_r[i] <= tmr_r[i] + 12'h001;
                end
              end
            end
            `ST_LOCK: st_r[i] <= `ST_LOCK;
            default: st_r[i] <= `ST_OFF;
          endcase
          if (sgo_v[i] && (st_r[i] == `ST_RAMP || st_r[i] == `ST_ON)) begin
            st_r[i] <= `ST_DOWN;
            tmr_r[i] <= 12'h000;
            rseq_r[i] <= presp == `RESP_RESEQ;
          end
        end
      end
    end
  end
endmodule

// ---- testbench/rail_supply_model.sv ----
`timescale 1ns/1ps
// rails and sensors feeding converter results, one result a clock
module rail_supply_model (
  input wire clk,
  input wire rst_n,
  input wire [9:0] rail_en_r,
  input wire [11:0] good_v,
  input wire [3:0] bad_rail,
  input wire [11:0] bad_v,
  input wire [11:0] die_t,
  input wire [11:0] rem_t,
  output reg adc_valid,
  output reg [3:0] adc_rail,
  output reg [1:0] adc_kind,
  output reg [11:0] adc_data
);
  reg [3:0] slot;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot <= 4'h0;
      adc_valid <= 1'b0;
      adc_rail <= 4'h0;
      adc_kind <= 2'h0;
      adc_data <= 12'h000;
    end else begin
      slot <= (slot == 4'hb) ? 4'h0 : slot + 4'h1;
      adc_valid <= 1'b1;
      adc_rail <= (slot == 4'hb) ? 4'h0 : slot;
      adc_kind <= (slot < 4'ha) ? 2'h0 : ((slot == 4'ha) ? 2'h2 : 2'h1);
      // a rail that is not enabled has decayed to ground
      if (slot < 4'ha)
        adc_data <= !rail_en_r[slot] ? 12'h000 : ((slot == bad_rail) ? bad_v : good_v);
      else
        adc_data <= (slot == 4'ha) ? die_t : rem_t;
    end
  end
endmodule

// ---- testbench/rail_fault_chk_monitor.sv ----
`timescale 1ns/1ps
module rail_fault_chk (
  input wire clk,
  input wire rst_n,
  input wire [8:0] addr,
  input wire [11:0] wdata,
  input wire wr,
  input wire rd,
  input wire [11:0] rdata_r,
  input wire adc_valid,
  input wire [3:0] adc_rail,
  input wire [1:0] adc_kind,
  input wire [11:0] adc_data,
  input wire rail_control_pin,
  input wire [9:0] rail_en_r,
  input wire alert_out_n,
  input wire warn_pin_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(rd) |-> rdata_r == 12'h000)
    else $error("read data not zero outside answer cycle");
  unmapped_zero_a: assert property ($past(rd) && $past(addr[8]) && $past(addr[3:2]) != 2'h0
    |-> rdata_r == 12'h000)
    else $error("unmapped read not zero");
  reset_idle_a: assert property ($rose(rst_n) |-> alert_out_n && !warn_pin_r && rail_en_r == 10'h000)
    else $error("outputs not idle after reset");
  cmd_off_a: assert property ((!rail_control_pin) [*6] |-> rail_en_r == 10'h000)
    else $error("enable kept with control pin low");
  warn_alert_a: assert property (warn_pin_r |-> ##[0:2] !alert_out_n)
    else $error("warning pin without alert");
  alert_release_a: assert property ($rose(alert_out_n) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("alert released without status write");
  alert_sticky_a: assert property (!alert_out_n && !wr && !$past(wr) |=> !alert_out_n)
    else $error("alert dropped by itself");
  warn_release_a: assert property ($fell(warn_pin_r) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3))
    else $error("warning pin dropped without write");
endmodule
bind rail_fault_monitor rail_fault_chk i_chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_r(rdata_r), .adc_valid(adc_valid), .adc_rail(adc_rail), .adc_kind(adc_kind),
  .adc_data(adc_data), .rail_control_pin(rail_control_pin), .rail_en_r(rail_en_r),
  .alert_out_n(alert_out_n), .warn_pin_r(warn_pin_r)
);

// ---- testbench/rail_fault_monitor_response_bench.sv ----
`timescale 1ns/1ps
`include "rail_fault_regs.vh"
module rail_fault_monitor_response_bench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [8:0] addr = 9'h000;
  reg [11:0] wdata = 12'h000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg ctl = 1'b1;
  reg [11:0] good_v = 12'h500;
  reg [11:0] bad_v = 12'h000;
  reg [3:0] bad_rail = 4'hf;
  reg [11:0] die_t = 12'h0a0;
  reg [11:0] rem_t = 12'h100;
  wire [11:0] rdata_r;
  wire adc_valid;
  wire [3:0] adc_rail;
  wire [1:0] adc_kind;
  wire [11:0] adc_data;
  wire [9:0] rail_en_r;
  wire alert_out_n;
  wire warn_pin_r;
  integer n_fail = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  reg [11:0] exp_q[$];
  reg [8:0] adr_q[$];
  reg rd_q = 1'b0;
  reg [11:0] hv;
  localparam [8:0] RON = {1'b0, `A_RAILON};
  always #12.5 clk = ~clk;
  rail_fault_monitor #(.SAMPLE_CYC(40), .TEMP_CYC(200), .STEP_CYC(20)) i_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .adc_valid(adc_valid), .adc_rail(adc_rail), .adc_kind(adc_kind),
    .adc_data(adc_data), .rail_control_pin(ctl), .rail_en_r(rail_en_r),
    .alert_out_n(alert_out_n), .warn_pin_r(warn_pin_r));
  rail_supply_model i_sup (
    .clk(clk), .rst_n(rst_n), .rail_en_r(rail_en_r), .good_v(good_v), .bad_rail(bad_rail),
    .bad_v(bad_v), .die_t(die_t), .rem_t(rem_t), .adc_valid(adc_valid),
    .adc_rail(adc_rail), .adc_kind(adc_kind), .adc_data(adc_data));
  task report_and_stop;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // read answers are checked here against the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) rem_t <= 12'h300;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
    if (rd_q) begin
      compares = compares + 1;
      if (rdata_r !== exp_q[0]) begin
        n_fail = n_fail + 1;
        $display("[FAIL] reg %h exp %h seen %h", adr_q[0], exp_q[0], rdata_r);
      end
      void'(exp_q.pop_front());
      void'(adr_q.pop_front());
    end
    rd_q <= rd;
  end
  function [8:0] ra(input [3:0] rl, input [3:0] f);
    ra = {1'b0, rl, f};
  endfunction
  task w(input [8:0] a, input [11:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task r(input [8:0] a, input [11:0] e);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge clk);
      rd <= 1'b0;
    end
  endtask
  task p(input string n, input [11:0] g, input [11:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %s exp %h seen %h", n, e, g);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task till(input integer n);
    while (cyc < n) @(posedge clk);
  endtask
  initial begin
    void'($urandom(41));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // registers, limits opened, status cleared
    w(ra(0, `F_CFG), 12'h200);
    for (i = 0; i < 10; i = i + 1) begin
      w(ra(i, `F_OVF), 12'hfff);
      w(ra(i, `F_OVW), 12'hfff);
      w(ra(i, `F_OTW), 12'hfff);
      w(ra(i, `F_OTF), 12'hfff);
    end
    for (i = 0; i < 10; i = i + 1) w(ra(i, `F_STAT), 12'hfff);
    wt(4);
    p("alert", alert_out_n, 12'h001);
    r(ra(0, `F_CFG), 12'h200);
    r(ra(5, `F_CFG), `CFG_RST);
    w(9'h105, 12'h5a5);
    r(9'h105, 12'h000);
    r(ra(4'hc, `F_CFG), 12'h000);
    r(9'h133, 12'h000);
    r(RON, 12'h000);
    $display("test 1 done");
    // host temperature on a rail without monitor input
    r(ra(1, `F_TEMP), 12'h0a0);
    hv = 12'h100 + ($urandom % 256);
    w(ra(1, `F_TEMP), hv);
    r(ra(1, `F_TEMP), hv);
    w(ra(1, `F_OTW), 12'h0ff);
    wt(4);
    r(ra(1, `F_STAT), 12'h040);
    p("alert", alert_out_n, 12'h000);
    r(9'h110, hv);
    w(ra(1, `F_OTW), 12'hfff);
    w(ra(1, `F_STAT), 12'h040);
    wt(4);
    p("alert", alert_out_n, 12'h001);
    $display("test 2 done");
    // rail 4 never reaches power-good and rises past its warning
    w(ra(4, `F_PGON), 12'hfff);
    w(ra(4, `F_NOM), 12'h800);
    w(ra(4, `F_TONMAX), 12'h003);
    w(ra(4, `F_OVW), 12'he00);
    w(ra(4, `F_UVW), 12'hfff);
    w(ra(4, `F_CFG), 12'h400);
    bad_rail <= 4'h4;
    bad_v <= 12'hf00;
    w(RON, 12'h010);
    wt(250);
    r(ra(4, `F_STAT), 12'h012);
    p("warn pin", warn_pin_r, 12'h001);
    r(9'h141, 12'h004);
    w(RON, 12'h000);
    wt(100);
    w(ra(4, `F_CFG), 12'h000);
    w(ra(4, `F_STAT), 12'hfff);
    wt(4);
    p("alert", alert_out_n, 12'h001);
    $display("test 4 done");
    // rail 2 undervoltage through glitch filter, shut, no restart
    bad_rail <= 4'hf;
    w(ra(2, `F_PGON), 12'h400);
    w(ra(2, `F_NOM), 12'h800);
    w(ra(2, `F_UVF), 12'h200);
    w(ra(2, `F_GLITCH), 12'h003);
    // ramp gets a few visits before a turn-on timeout can fire
    w(ra(2, `F_TONMAX), 12'h003);
    w(ra(2, `F_CFG), 12'h101);
    w(RON, 12'h004);
    wt(150);
    p("rail 2 en", rail_en_r[2], 12'h001);
    r(9'h123, 12'h002);
    bad_rail <= 4'h2;
    bad_v <= 12'h100;
    wt(60);
    r(9'h121, 12'h002);
    p("rail 2 en", rail_en_r[2], 12'h001);
    wt(200);
    p("rail 2 en", rail_en_r[2], 12'h000);
    r(9'h123, 12'h005);
    wt(300);
    p("rail 2 en", rail_en_r[2], 12'h000);
    r(ra(2, `F_STAT), 12'h008);
    $display("test 5 done");
    // rail 7 never good: turn-on timeout, shut, one restart, then locked
    w(ra(7, `F_PGON), 12'hfff);
    w(ra(7, `F_TONMAX), 12'h003);
    w(ra(7, `F_CFG), 12'h015);
    w(RON, 12'h084);
    wt(600);
    r(9'h173, 12'h00d);
    r(9'h171, 12'h004);
    $display("test 7 done");
    // sliding average on the monitored rail 0, then host override
    till(3000);
    r(ra(0, `F_TEMP), 12'h200);
    till(5000);
    r(ra(0, `F_TEMP), 12'h255);
    w(ra(0, `F_TEMP), 12'h050);
    till(6600);
    r(ra(0, `F_TEMP), 12'h050);
    $display("test 3 done");
    // command off through the control pin
    w(ra(6, `F_TONMAX), 12'hfff);
    w(ra(6, `F_PGON), 12'h400);
    w(RON, 12'h044);
    wt(100);
    p("rail 6 en", rail_en_r[6], 12'h001);
    ctl <= 1'b0;
    wt(10);
    p("enables", rail_en_r, 12'h000);
    // a rail in shutdown leaves it only on its next voltage visit
    wt(40);
    r(9'h123, 12'h000);
    r(9'h173, 12'h000);
    while (exp_q.size() != 0) @(posedge clk);
    $display("test 6 done");
    report_and_stop;
  end
endmodule
